// ===== pkg/ccw_consts.vh
`ifndef CCW_CONSTS_VH
`define CCW_CONSTS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define CCW_OFF_TX_DIV_A    8'h00
`define CCW_OFF_TX_TRIM     8'h04
`define CCW_OFF_TX_DIV_B    8'h08
`define CCW_OFF_RX_DIV_A    8'h0c
`define CCW_OFF_RX_TRIM     8'h10
`define CCW_OFF_RX_DIV_B    8'h14
`define CCW_OFF_CONTROL     8'h18
`define CCW_OFF_STATUS      8'h1c
`define CCW_OFF_PRIMARY     8'h20
`define CCW_OFF_SECONDARY   8'h24

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define CCW_RST_DIV_A       6'h09
`define CCW_RST_TRIM        6'h01
`define CCW_RST_DIV_B       6'h24
`define CCW_RST_CONTROL     10'h2e4

// ------------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------------
`define CCW_CTL_LOOPBACK    3
`define CCW_CTL_SYNC        5

// ------------------------------------------------------------------
// Primary word load options (low two bits)
// ------------------------------------------------------------------
`define CCW_SEL_PLAIN       2'b00
`define CCW_SEL_PLUS        2'b01
`define CCW_SEL_MINUS       2'b10
`define CCW_SEL_SECONDARY   2'b11

// ------------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------------
`define CCW_SHIFT_DIV       3'h4
`define CCW_WORD_BITS       5'h10
`define CCW_SEC_GAP         5'h04

`endif

// ===== core/ccw_core.v
`timescale 1ns/100ps
`default_nettype none
`include "ccw_consts.vh"

module ccw_core
#(
  parameter DIV_W = 6,
  parameter DAC_W = 14
)
(
  // Clock, reset and enable
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             clk_en,
  // AHB-Lite slave
  input  wire             hsel,
  input  wire [7:0]       haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output reg  [31:0]      hrdata,
  output reg              hreadyout,
  output reg              hresp,
  // Serial link to the processor
  output reg              shift_clk,
  output reg              tx_frame_sync,
  output reg              rx_frame_sync,
  input  wire             serial_tx_data,
  output reg              serial_rx_data,
  // Converter side
  input  wire [DAC_W-1:0] adc_sample,
  output reg  [DAC_W-1:0] dac_sample,
  output reg              dac_strobe,
  output reg              adc_strobe,
  output reg              tx_sc_filter_clock,
  output reg              rx_sc_filter_clock,
  output reg              hp_filter_clock,
  output reg              loopback_en,
  output reg              sync_mode,
  output reg  [9:0]       control_word
);

  // ------------------------------------------------------------------
  // Programmable registers
  // ------------------------------------------------------------------
  reg  [DIV_W-1:0] tx_divider_a;
  reg  [DIV_W-1:0] tx_trim;
  reg  [DIV_W-1:0] tx_divider_b;
  reg  [DIV_W-1:0] rx_divider_a;
  reg  [DIV_W-1:0] rx_trim;
  reg  [DIV_W-1:0] rx_divider_b;
  reg  [9:0]       control;
  reg  [15:0]      primary_word;
  reg  [15:0]      secondary_word;

  reg              dph_write;
  reg  [7:0]       dph_addr;
  reg              rd_wait;
  reg  [31:0]      rd_mux;

  wire             addr_phase = hsel & htrans[1] & hready;
  wire [DIV_W-1:0] wr_b       = (hwdata[DIV_W-1:0] < 2) ? `CCW_RST_DIV_B : hwdata[DIV_W-1:0];

  // ------------------------------------------------------------------
  // Divider chains, one per path
  // ------------------------------------------------------------------
  reg              trim_req;
  reg  [1:0]       trim_new;
  wire [1:0]       path_strobe;
  wire [1:0]       path_scf;

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : path
      wire [DIV_W-1:0] a_reg  = (p == 0) ? tx_divider_a : rx_divider_a;
      wire [DIV_W-1:0] t_reg  = (p == 0) ? tx_trim : rx_trim;
      wire [DIV_W-1:0] b_reg  = (p == 0) ? tx_divider_b : rx_divider_b;
      wire [DIV_W-1:0] a_plus = a_reg + t_reg;
      wire [DIV_W-1:0] a_mins = a_reg - t_reg;
      reg  [DIV_W-1:0] a_load;
      reg  [DIV_W-1:0] a_cnt;
      reg  [DIV_W-1:0] b_cnt;
      reg  [1:0]       trim_sel;
      reg              sc_filter_clock;
      reg              strobe;

      // Trimmed loads wrap modulo 64; a result of 0 or 1 falls back to the plain value.
      always @*
      begin
        case (trim_sel)
          `CCW_SEL_PLUS:  a_load = (a_plus < 2) ? a_reg : a_plus;
          `CCW_SEL_MINUS: a_load = (a_mins < 2) ? a_reg : a_mins;
          default:        a_load = a_reg;
        endcase
      end

      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          a_cnt    <= `CCW_RST_DIV_A;
          b_cnt    <= `CCW_RST_DIV_B;
          trim_sel <= `CCW_SEL_PLAIN;
          sc_filter_clock      <= 1'b0;
          strobe   <= 1'b0;
        end
        else if (clk_en)
        begin
          strobe <= 1'b0;
          // A divider of 0 or 1 stops the path.
          if (a_reg >= 2)
          begin
            if (a_cnt <= 1)
            begin
              a_cnt <= a_load;
              sc_filter_clock   <= ~sc_filter_clock;
              if (trim_sel != `CCW_SEL_PLAIN)
                trim_sel <= `CCW_SEL_PLAIN;
              if (!sc_filter_clock)
              begin
                if (b_cnt <= 1)
                begin
                  b_cnt  <= b_reg;
                  strobe <= 1'b1;
                end
                else
                  b_cnt <= b_cnt - 1'b1;
              end
            end
            else
              a_cnt <= a_cnt - 1'b1;
          end
          if (trim_req)
            trim_sel <= trim_new;
        end
      end

      assign path_strobe[p] = strobe;
      assign path_scf[p]    = sc_filter_clock;
    end
  endgenerate

  wire sync_sel = control[`CCW_CTL_SYNC];
  wire rx_conv  = sync_sel ? path_strobe[0] : path_strobe[1];

  // ------------------------------------------------------------------
  // Shift clock and input synchroniser
  // ------------------------------------------------------------------
  reg  [1:0] sc_div;
  reg        din_meta;
  reg        din_sync;
  wire       tick = (sc_div == 2'b01);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sc_div   <= 2'b00;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end
    else if (clk_en)
    begin
      sc_div   <= sc_div + 2'b01;
      din_meta <= serial_tx_data;
      din_sync <= din_meta;
    end
  end

  // ------------------------------------------------------------------
  // Transmit frame sequencer
  // ------------------------------------------------------------------
  localparam TX_IDLE = 2'b00;
  localparam TX_PRIM = 2'b01;
  localparam TX_GAP  = 2'b10;
  localparam TX_SEC  = 2'b11;

  reg  [1:0]  tx_state;
  reg  [4:0]  tx_bits;
  reg  [15:0] tx_shift;
  reg         tx_pend;
  reg         rx_pend;
  reg         rx_busy;
  reg  [4:0]  rx_bits;
  reg  [15:0] rx_shift;
  wire [15:0] tx_word = {tx_shift[14:0], din_sync};
  wire [DAC_W-1:0] adc_src = control[`CCW_CTL_LOOPBACK] ? dac_sample : adc_sample;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_state       <= TX_IDLE;
      tx_bits        <= 5'h00;
      tx_shift       <= 16'h0000;
      tx_pend        <= 1'b0;
      tx_frame_sync  <= 1'b1;
      primary_word   <= 16'h0000;
      secondary_word <= 16'h0000;
      dac_sample     <= {DAC_W{1'b0}};
      trim_req       <= 1'b0;
      trim_new       <= `CCW_SEL_PLAIN;
    end
    else if (clk_en)
    begin
      trim_req <= 1'b0;
      if (tick)
      begin
        case (tx_state)
          TX_IDLE:
          begin
            if (tx_pend)
            begin
              tx_pend       <= 1'b0;
              tx_state      <= TX_PRIM;
              tx_bits       <= `CCW_WORD_BITS;
              tx_frame_sync <= 1'b0;
            end
          end
          TX_PRIM, TX_SEC:
          begin
            tx_shift <= tx_word;
            tx_bits  <= tx_bits - 5'h01;
            if (tx_bits == 5'h01)
            begin
              tx_frame_sync <= 1'b1;
              tx_state      <= TX_IDLE;
              if (tx_state == TX_SEC)
                secondary_word <= tx_word;
              else
              begin
                primary_word <= tx_word;
                dac_sample   <= tx_word[15:2];
                trim_req     <= 1'b1;
                trim_new     <= (tx_word[1:0] == `CCW_SEL_SECONDARY) ? `CCW_SEL_PLAIN : tx_word[1:0];
                if (tx_word[1:0] == `CCW_SEL_SECONDARY)
                begin
                  tx_state <= TX_GAP;
                  tx_bits  <= `CCW_SEC_GAP;
                end
              end
            end
          end
          TX_GAP:
          begin
            tx_bits <= tx_bits - 5'h01;
            if (tx_bits == 5'h01)
            begin
              tx_state      <= TX_SEC;
              tx_bits       <= `CCW_WORD_BITS;
              tx_frame_sync <= 1'b0;
            end
          end
          default:
            tx_state <= TX_IDLE;
        endcase
      end
      // A conversion that lands on the tick that consumes the request is kept.
      if (path_strobe[0])
        tx_pend <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Receive frame sequencer
  // ------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_pend        <= 1'b0;
      rx_busy        <= 1'b0;
      rx_bits        <= 5'h00;
      rx_shift       <= 16'h0000;
      rx_frame_sync  <= 1'b1;
      serial_rx_data <= 1'b0;
    end
    else if (clk_en)
    begin
      if (tick)
      begin
        if (rx_busy)
        begin
          serial_rx_data <= rx_shift[15];
          rx_shift       <= {rx_shift[14:0], 1'b0};
          rx_bits        <= rx_bits - 5'h01;
          if (rx_bits == 5'h01)
          begin
            rx_busy       <= 1'b0;
            rx_frame_sync <= 1'b1;
          end
        end
        // In synchronous mode the receive frame follows primary frames only.
        else if (rx_pend && (!sync_sel || (tx_state == TX_IDLE && tx_pend)))
        begin
          rx_pend       <= 1'b0;
          rx_busy       <= 1'b1;
          rx_bits       <= `CCW_WORD_BITS;
          rx_shift      <= {adc_src, 2'b00};
          rx_frame_sync <= 1'b0;
        end
      end
      if (rx_conv)
        rx_pend <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shift_clk          <= 1'b0;
      dac_strobe         <= 1'b0;
      adc_strobe         <= 1'b0;
      tx_sc_filter_clock <= 1'b0;
      rx_sc_filter_clock <= 1'b0;
      hp_filter_clock    <= 1'b0;
      loopback_en        <= 1'b0;
      sync_mode          <= 1'b1;
      control_word       <= `CCW_RST_CONTROL;
    end
    else if (clk_en)
    begin
      // High over phases 2 and 3, so a bit driven on its rise is two flops deep at the tick.
      shift_clk          <= sc_div[1] ^ sc_div[0];
      dac_strobe         <= path_strobe[0];
      adc_strobe         <= rx_conv;
      tx_sc_filter_clock <= path_scf[0];
      rx_sc_filter_clock <= sync_sel ? path_scf[0] : path_scf[1];
      hp_filter_clock    <= rx_conv;
      loopback_en        <= control[`CCW_CTL_LOOPBACK];
      sync_mode          <= sync_sel;
      control_word       <= control;
    end
  end

  // ------------------------------------------------------------------
  // AHB-Lite register access
  // ------------------------------------------------------------------
  always @*
  begin
    rd_mux = 32'h00000000;
    case (dph_addr)
      `CCW_OFF_TX_DIV_A:  rd_mux[DIV_W-1:0] = tx_divider_a;
      `CCW_OFF_TX_TRIM:   rd_mux[DIV_W-1:0] = tx_trim;
      `CCW_OFF_TX_DIV_B:  rd_mux[DIV_W-1:0] = tx_divider_b;
      `CCW_OFF_RX_DIV_A:  rd_mux[DIV_W-1:0] = rx_divider_a;
      `CCW_OFF_RX_TRIM:   rd_mux[DIV_W-1:0] = rx_trim;
      `CCW_OFF_RX_DIV_B:  rd_mux[DIV_W-1:0] = rx_divider_b;
      `CCW_OFF_CONTROL:   rd_mux[9:0]       = control;
      `CCW_OFF_STATUS:    rd_mux[7:0]       = {path[0].trim_sel, rx_busy, rx_pend, tx_pend, 1'b0, tx_state};
      `CCW_OFF_PRIMARY:   rd_mux[15:0]      = primary_word;
      `CCW_OFF_SECONDARY: rd_mux[15:0]      = secondary_word;
      default:            rd_mux            = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_divider_a <= `CCW_RST_DIV_A;
      tx_trim      <= `CCW_RST_TRIM;
      tx_divider_b <= `CCW_RST_DIV_B;
      rx_divider_a <= `CCW_RST_DIV_A;
      rx_trim      <= `CCW_RST_TRIM;
      rx_divider_b <= `CCW_RST_DIV_B;
      control      <= `CCW_RST_CONTROL;
      dph_write    <= 1'b0;
      dph_addr     <= 8'h00;
      rd_wait      <= 1'b0;
      hrdata       <= 32'h00000000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end
    else if (clk_en)
    begin
      hresp <= 1'b0;
      if (dph_write)
      begin
        dph_write <= 1'b0;
        case (dph_addr)
          `CCW_OFF_TX_DIV_A: tx_divider_a <= hwdata[DIV_W-1:0];
          `CCW_OFF_TX_TRIM:  tx_trim      <= hwdata[DIV_W-1:0];
          `CCW_OFF_TX_DIV_B: tx_divider_b <= wr_b;
          `CCW_OFF_RX_DIV_A: rx_divider_a <= hwdata[DIV_W-1:0];
          `CCW_OFF_RX_TRIM:  rx_trim      <= hwdata[DIV_W-1:0];
          `CCW_OFF_RX_DIV_B: rx_divider_b <= wr_b;
          `CCW_OFF_CONTROL:  control      <= hwdata[9:0];
          default:           control      <= control;
        endcase
      end
      if (rd_wait)
      begin
        rd_wait   <= 1'b0;
        hrdata    <= rd_mux;
        hreadyout <= 1'b1;
      end
      else if (addr_phase)
      begin
        dph_addr  <= {haddr[7:2], 2'b00};
        dph_write <= hwrite;
        if (!hwrite)
        begin
          rd_wait   <= 1'b1;
          hreadyout <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== test/ccw_core_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ccw_chk (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Register bus
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Serial link and converter timing
  input wire logic       shift_clk,
  input wire logic       tx_frame_sync,
  input wire logic       rx_frame_sync,
  input wire logic       dac_strobe,
  input wire logic       adc_strobe,
  input wire logic       tx_sc_filter_clock,
  input wire logic       rx_sc_filter_clock,
  input wire logic       hp_filter_clock,
  input wire logic       sync_mode
);
  // ----------------------------------------------------------------
  // Frame sync run lengths
  // ----------------------------------------------------------------
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Both counters saturate so a stuck frame sync cannot wrap into a pass.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      low_cnt  <= 8'h00;
      high_cnt <= 8'h00;
    end
    else
    begin
      low_cnt  <= tx_frame_sync ? 8'h00 : low_cnt + {7'h00, ~&low_cnt};
      high_cnt <= !tx_frame_sync ? 8'h00 : high_cnt + {7'h00, ~&high_cnt};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_shift_cycle;
    shift_clk [*2] ##1 !shift_clk [*2] ##1 shift_clk;
  endsequence
  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_shift_div: assert property ($rose(shift_clk) |-> s_shift_cycle)
    else $error("shift clock is not the master clock divided by four");
  a_frame_len: assert property ($rose(tx_frame_sync) |-> low_cnt == 8'h40)
    else $error("transmit frame not sixteen shift clocks long");
  a_sec_gap: assert property ($fell(tx_frame_sync) |-> high_cnt == 8'h10 || high_cnt > 8'h28)
    else $error("short gap before a frame is not four shift clocks");
  a_sec_no_rx: assert property ($fell(tx_frame_sync) && high_cnt == 8'h10 && sync_mode
    |-> rx_frame_sync until tx_frame_sync)
    else $error("receive frame sync asserted during a secondary exchange");
  a_hp_adc: assert property (hp_filter_clock == adc_strobe)
    else $error("high-pass filter clock differs from the conversion strobe");
  a_sync_strobe: assert property (sync_mode && dac_strobe |-> adc_strobe)
    else $error("synchronous mode conversions are not shared");
  a_sync_filter: assert property (sync_mode |-> rx_sc_filter_clock == tx_sc_filter_clock)
    else $error("synchronous mode filter clocks differ");
  a_strobe_pulse: assert property ($rose(dac_strobe) |=> !dac_strobe [*8])
    else $error("conversion strobe longer than one cycle or too frequent");
  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> s_read_wait)
    else $error("read answer not after one wait cycle");
  a_write_zero: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("bus response not okay");
endmodule

bind ccw_core ccw_chk i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .shift_clk(shift_clk),
  .tx_frame_sync(tx_frame_sync), .rx_frame_sync(rx_frame_sync), .dac_strobe(dac_strobe),
  .adc_strobe(adc_strobe), .tx_sc_filter_clock(tx_sc_filter_clock),
  .rx_sc_filter_clock(rx_sc_filter_clock), .hp_filter_clock(hp_filter_clock), .sync_mode(sync_mode)
);
`default_nettype wire

// ===== test/ccw_dsp_model.sv
`timescale 1ns/100ps
`default_nettype none
module ccw_dsp_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Serial link
  input  wire logic        shift_clk,
  input  wire logic        tx_frame_sync,
  input  wire logic        rx_frame_sync,
  input  wire logic        serial_rx_data,
  output var  logic        serial_tx_data,
  // Words sent and received
  input  wire logic [15:0] primary_word,
  input  wire logic [15:0] secondary_word,
  output var  logic [15:0] rx_word
);
  logic        sc_q;
  logic        rx_fs_q;
  logic        sec_next;
  logic [4:0]  tx_idx;
  logic [4:0]  rx_idx;
  logic [15:0] cur;
  logic [15:0] rx_sh;
  wire  [15:0] word_now = (tx_idx == 5'h00) ? (sec_next ? secondary_word : primary_word) : cur;

  // ----------------------------------------------------------------
  // Processor serial port
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sc_q           <= 1'b0;
      rx_fs_q        <= 1'b1;
      sec_next       <= 1'b0;
      tx_idx         <= 5'h00;
      rx_idx         <= 5'h00;
      cur            <= 16'h0000;
      rx_sh          <= 16'h0000;
      rx_word        <= 16'h0000;
      serial_tx_data <= 1'b0;
    end
    else
    begin
      sc_q    <= shift_clk;
      rx_fs_q <= rx_frame_sync;
      if (tx_frame_sync)
      begin
        // Outside a frame the line toggles, so a stale bit never looks valid.
        serial_tx_data <= ~serial_tx_data;
        tx_idx         <= 5'h00;
        if (tx_idx == 5'h10)
          sec_next <= !sec_next && (cur[1:0] == 2'b11);
      end
      else if (shift_clk && !sc_q && tx_idx != 5'h10)
      begin
        cur            <= word_now;
        serial_tx_data <= word_now[4'hf - tx_idx[3:0]];
        tx_idx         <= tx_idx + 5'h01;
      end
      // The last bit leaves as the frame sync rises, so the frame is judged two cycles late.
      if (!rx_fs_q && shift_clk && !sc_q)
      begin
        rx_sh  <= {rx_sh[14:0], serial_rx_data};
        rx_idx <= rx_idx + 5'h01;
      end
      else if (rx_frame_sync && rx_fs_q)
      begin
        rx_idx <= 5'h00;
        if (rx_idx == 5'h10)
          rx_word <= rx_sh;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccw_consts.vh"
module tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [15:0] pri_word;
  logic [15:0] sec_word;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         shift_clk;
  wire         tx_frame_sync;
  wire         rx_frame_sync;
  wire         serial_tx_data;
  wire         serial_rx_data;
  wire  [13:0] dac_sample;
  wire         dac_strobe;
  wire         adc_strobe;
  wire         tx_sc_filter_clock;
  wire         rx_sc_filter_clock;
  wire         hp_filter_clock;
  wire         loopback_en;
  wire         sync_mode;
  wire  [9:0]  control_word;
  wire  [15:0] rx_word;
  int          failures;
  int          checks_done;
  int          n;
  logic [31:0] rst_val [6] = '{32'h09, 32'h01, 32'h24, 32'h09, 32'h01, 32'h24};
  logic [15:0] words [4]   = '{16'h9a58, 16'h3c35, 16'hc7a6, 16'h5e1f};
  int          adj [4]     = '{0, 3, -3, 0};

  ccw_core i_dut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .shift_clk(shift_clk), .tx_frame_sync(tx_frame_sync),
    .rx_frame_sync(rx_frame_sync), .serial_tx_data(serial_tx_data), .serial_rx_data(serial_rx_data),
    .adc_sample(14'h0abc), .dac_sample(dac_sample), .dac_strobe(dac_strobe), .adc_strobe(adc_strobe),
    .tx_sc_filter_clock(tx_sc_filter_clock), .rx_sc_filter_clock(rx_sc_filter_clock),
    .hp_filter_clock(hp_filter_clock), .loopback_en(loopback_en), .sync_mode(sync_mode),
    .control_word(control_word)
  );
  ccw_dsp_model i_dsp (
    .hclk(hclk), .hresetn(hresetn), .shift_clk(shift_clk), .tx_frame_sync(tx_frame_sync),
    .rx_frame_sync(rx_frame_sync), .serial_rx_data(serial_rx_data), .serial_tx_data(serial_tx_data),
    .primary_word(pri_word), .secondary_word(sec_word), .rx_word(rx_word)
  );

  // ----------------------------------------------------------------
  // Bus and measurement tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_ready();
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(r, exp, what);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return dac_strobe;
      1: return adc_strobe;
      2: return tx_sc_filter_clock;
      default: return rx_sc_filter_clock;
    endcase
  endfunction
  // Cycles between two rising edges of the chosen signal; the second of two passes settles.
  task automatic period(input int w, output int cyc);
    int k;
    int t;
    logic p;
    k = 0;
    t = 0;
    cyc = 0;
    p = 1'b1;
    repeat (2)
    begin
      k = 0;
      cyc = 0;
      while (k < 2 && t++ < 4000)
      begin
        @(posedge hclk);
        if (k == 1)
          cyc++;
        if (pick(w) === 1'b1 && p === 1'b0)
          k++;
        p = pick(w);
      end
    end
    if (t > 4000)
    begin
      failures++;
      $display("mismatch at %0t: no edges on signal %0d", $time, w);
    end
  endtask
  task automatic done(input string t);
    $display("test %s finished, %0d mismatches so far", t, failures);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial
  begin
    #(40 * 60000);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pri_word = 16'h0000;
    sec_word = 16'h5a3c;
    failures = 0;
    checks_done = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd_chk(8'(4 * i), rst_val[i], "reset divider");
    rd_chk(`CCW_OFF_CONTROL, 32'h2e4, "reset control");
    check({22'h0, control_word}, 32'h2e4, "control port");
    check({31'h0, sync_mode}, 32'h1, "sync after reset");
    check({31'h0, loopback_en}, 32'h0, "loopback after reset");
    rd_chk(8'h40, 32'h0, "unmapped read");
    done("reset");
    wr(`CCW_OFF_TX_DIV_B, 32'h0);
    rd_chk(`CCW_OFF_TX_DIV_B, 32'h24, "tx b of zero");
    wr(`CCW_OFF_RX_DIV_B, 32'h1);
    rd_chk(`CCW_OFF_RX_DIV_B, 32'h24, "rx b of one");
    done("divider b guard");
    wr(`CCW_OFF_TX_DIV_A, 32'h0c);
    wr(`CCW_OFF_TX_TRIM, 32'h03);
    wr(`CCW_OFF_TX_DIV_B, 32'h0a);
    period(2, n);
    check(n, 32'd24, "tx filter clock");
    for (int s = 0; s < 4; s++)
    begin
      pri_word <= words[s];
      period(0, n);
      period(0, n);
      check(n, 32'(240 + adj[s]), "dac period");
      period(1, n);
      check(n, 32'(240 + adj[s]), "adc period in sync mode");
      check({18'h0, dac_sample}, {18'h0, words[s][15:2]}, "dac sample");
    end
    rd_chk(`CCW_OFF_SECONDARY, {16'h0, sec_word}, "secondary word");
    pri_word <= words[0];
    done("sync timing");
    wr(`CCW_OFF_CONTROL, 32'h2c4);
    repeat (2) @(posedge hclk);
    check({31'h0, sync_mode}, 32'h0, "async selected");
    wr(`CCW_OFF_RX_DIV_A, 32'h08);
    wr(`CCW_OFF_RX_DIV_B, 32'h0e);
    period(3, n);
    check(n, 32'd16, "rx filter clock");
    period(1, n);
    check(n, 32'd224, "adc period async");
    period(0, n);
    check(n, 32'd240, "dac period async");
    check({16'h0, rx_word}, 32'h00002af0, "adc word");
    done("async timing");
    wr(`CCW_OFF_CONTROL, 32'h2cc);
    repeat (2) @(posedge hclk);
    check({31'h0, loopback_en}, 32'h1, "loopback on");
    period(1, n);
    period(1, n);
    check({18'h0, rx_word[15:2]}, {18'h0, words[0][15:2]}, "looped word");
    done("loopback");
    tally_and_finish();
  end
endmodule
`default_nettype wire
